// file: sps_regs.svh
// Sequencer constants: offsets, fields, timing counts
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define SPS_CLK_MHZ 125

// ----------------------------------------------------------------
// Device register offsets on the control link (byte addresses)
// ----------------------------------------------------------------
`define SPS_ADR_RUN 16'h0100
`define SPS_ADR_FAST 16'h0106
`define SPS_ADR_EXPO 16'h0110
`define SPS_RUN_ON 8'h01
`define SPS_RUN_OFF 8'h00
`define SPS_FAST_ON 8'h01

// ----------------------------------------------------------------
// Device timing: times in their own unit, counts derived
// ----------------------------------------------------------------
`define SPS_REL_MAX_US 200
`define SPS_REL_MAX_CYC (`SPS_REL_MAX_US * `SPS_CLK_MHZ)
`define SPS_INIT_MAX_CLK 32000
`define SPS_WAKE_US 1200
`define SPS_WAKE_CYC (`SPS_WAKE_US * `SPS_CLK_MHZ)
`define SPS_CLR_FALL_US 10
`define SPS_CLR_FALL_CYC (`SPS_CLR_FALL_US * `SPS_CLK_MHZ)

// ----------------------------------------------------------------
// Frame geometry in clock cycles and lines
// ----------------------------------------------------------------
`define SPS_LINE_LEN 16'd64
`define SPS_ACT_COLS 16'd48
`define SPS_FRAME_LINES 16'd40
`define SPS_ACT_LINES 16'd32

// ----------------------------------------------------------------
// Host timing
// ----------------------------------------------------------------
`define SPS_VREF_MS 6
`define SPS_VREF_CYC (`SPS_VREF_MS * 1000 * `SPS_CLK_MHZ)

// ----------------------------------------------------------------
// Host APB register map and fields
// ----------------------------------------------------------------
`define SPS_APB_CTRL 12'h000
`define SPS_APB_EXPO 12'h004
`define SPS_APB_STAT 12'h008
`define SPS_CTRL_PWR 0
`define SPS_CTRL_RUN 1
`define SPS_CTRL_FAST 2
`define SPS_ST_CLR 0
`define SPS_ST_STBY 1
`define SPS_ST_FV 2
`define SPS_ST_QOK 3
`define SPS_ST_BUSY 4
`define SPS_ST_VREF 5

`endif

// file: sps_pkg.sv
// Types shared by both ends of the sensor power and standby sequencer
`default_nettype none
package sps_pkg;
    // Device sequencing states
    typedef enum logic [2:0] {
        SPS_D_RST = 3'b000,
        SPS_D_INIT = 3'b001,
        SPS_D_STBY = 3'b010,
        SPS_D_WAKE = 3'b011,
        SPS_D_STREAM = 3'b100
    } sps_dev_st_t;
    // Host link command states
    typedef enum logic [1:0] {
        SPS_H_IDLE = 2'b00,
        SPS_H_FAST = 2'b01,
        SPS_H_EXPO = 2'b10,
        SPS_H_RUN = 2'b11
    } sps_host_st_t;
endpackage
`default_nettype wire

// file: sps_link_if.sv
// Host to sensor link: clear pin, control writes, frame status
`default_nettype none
interface sps_link_if;
    logic ext_clear_n; // Active-low clear pin, host driven
    logic cci_req; // Control request, held until ack
    logic cci_we; // Write when high
    logic [15:0] cci_addr; // Register address
    logic [7:0] cci_wdata; // Write data
    logic cci_ack; // One-cycle answer
    logic [7:0] cci_rdata; // Read data, valid with ack
    logic standby; // Sensor in software standby
    logic frame_valid; // Active frame lines
    logic line_valid; // Active pixels of a line
    logic quality_ok; // Image settled after first frame
    modport dev (input ext_clear_n, cci_req, cci_we, cci_addr, cci_wdata,
                 output cci_ack, cci_rdata, standby, frame_valid, line_valid, quality_ok);
    modport host (output ext_clear_n, cci_req, cci_we, cci_addr, cci_wdata,
                  input cci_ack, cci_rdata, standby, frame_valid, line_valid, quality_ok);
endinterface
`default_nettype wire

// file: sps_dev.sv
// Sensor end: internal reset, silicon init, wake-up, frame timing and standby entry
//
// Design decision made in the host end: the APB register port.
`include "sps_regs.svh"
`default_nettype none

// Summary of operation
// - Host holds clear low until supplies settle
// - Internal reset rises within 200 us
// - Host waits 6 ms before leaving standby
// - Silicon init done within 32000 reference clocks
// - Streaming waits 1.2 ms plus exposure
// - Image quality settles within one frame
// - Host programs settings, then writes run
// - First frame follows wake and init time
// - Standby entered within one frame time
// - Clear may fall only after standby
// - Internal reset falls within 10 us
// - Fast standby register enables fast stop
// - Fast standby stops at end of line
// - Request inside frame finishes the frame
// - Request in blanking stops at once
module sps_dev
    import sps_pkg::*;
#(
    parameter int REL_CYC = 16, // Clear-high to internal release
    parameter int INIT_CLK = `SPS_INIT_MAX_CLK, // Silicon init length
    parameter int WAKE_CYC = `SPS_WAKE_CYC // Fixed part of wake-up
) (
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    sps_link_if.dev LINK,
    output logic INT_RST_N_O,
    output logic [2:0] STATE_O
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic int_rst_n_r; // Internal reset, low active
    logic [31:0] rel_cnt_r; // Release delay counter
    sps_dev_st_t st_r; // Sequencing state
    logic [31:0] tmr_r; // Init and wake counter
    logic [7:0] run_r; // Run control register
    logic [7:0] fast_r; // Fast standby register
    logic [7:0] expo_r; // Exposure in lines
    logic ack_r; // Link answer
    logic [7:0] rdata_r; // Link read data
    logic [15:0] col_r; // Cycle within line
    logic [15:0] line_r; // Line within frame
    logic qok_r; // Quality settled
    logic wr; // Accepted write this cycle
    logic line_end; // Last cycle of a line
    logic act_end; // Last cycle of last active line
    logic in_blank; // Frame blanking
    logic [31:0] wake_len; // Total wake time in cycles

    // Register read mux
    function automatic logic [7:0] rd_mux(input logic [15:0] a, input logic [7:0] r,
                                          input logic [7:0] f, input logic [7:0] e);
        case (a)
            `SPS_ADR_RUN: rd_mux = r;
            `SPS_ADR_FAST: rd_mux = f;
            `SPS_ADR_EXPO: rd_mux = e;
            default: rd_mux = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Internal reset
    // ------------------------------------------------------------
    // Falls one edge after clear, far inside 10 us
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            int_rst_n_r <= 1'b0;
            rel_cnt_r <= 32'h0;
        end else if (!LINK.ext_clear_n) begin
            int_rst_n_r <= 1'b0;
            rel_cnt_r <= 32'h0;
        end else if (!int_rst_n_r) begin
            // Short fixed delay, well below the 200 us ceiling
            if (rel_cnt_r >= 32'(REL_CYC - 1)) begin
                int_rst_n_r <= 1'b1;
            end else begin
                rel_cnt_r <= rel_cnt_r + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Control link slave
    // ------------------------------------------------------------
    // One answer per request; writes need reset high
    assign wr = LINK.cci_req && !ack_r && LINK.cci_we && int_rst_n_r;

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ack_r <= 1'b0;
            rdata_r <= 8'h00;
        end else begin
            ack_r <= LINK.cci_req && !ack_r;
            if (LINK.cci_req && !ack_r && !LINK.cci_we) begin
                rdata_r <= rd_mux(LINK.cci_addr, run_r, fast_r, expo_r);
            end
        end
    end

    // Registers cleared in internal reset
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            run_r <= 8'h00;
            fast_r <= 8'h00;
            expo_r <= 8'h00;
        end else if (!int_rst_n_r) begin
            run_r <= 8'h00;
            fast_r <= 8'h00;
            expo_r <= 8'h00;
        end else if (wr) begin
            case (LINK.cci_addr)
                `SPS_ADR_RUN: run_r <= LINK.cci_wdata;
                `SPS_ADR_FAST: fast_r <= LINK.cci_wdata;
                `SPS_ADR_EXPO: expo_r <= LINK.cci_wdata;
                default: ; // Unmapped writes dropped
            endcase
        end
    end

    // ------------------------------------------------------------
    // Frame timing
    // ------------------------------------------------------------
    assign line_end = (col_r == `SPS_LINE_LEN - 16'd1);
    assign act_end = line_end && (line_r == `SPS_ACT_LINES - 16'd1);
    assign in_blank = (line_r >= `SPS_ACT_LINES);
    assign wake_len = 32'(WAKE_CYC) + 32'(expo_r) * 32'(`SPS_LINE_LEN);

    // Counters run only while streaming
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            col_r <= 16'h0;
            line_r <= 16'h0;
        end else if (st_r != SPS_D_STREAM) begin
            col_r <= 16'h0;
            line_r <= 16'h0;
        end else if (line_end) begin
            col_r <= 16'h0;
            line_r <= (line_r == `SPS_FRAME_LINES - 16'd1) ? 16'h0 : line_r + 16'h1;
        end else begin
            col_r <= col_r + 16'h1;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_r <= SPS_D_RST;
            tmr_r <= 32'h0;
        end else if (!int_rst_n_r) begin
            st_r <= SPS_D_RST;
            tmr_r <= 32'h0;
        end else begin
            case (st_r)
                SPS_D_RST: begin
                    st_r <= SPS_D_INIT;
                    tmr_r <= 32'h0;
                end
                SPS_D_INIT: begin
                    // Fixed length, equal to the init ceiling
                    if (tmr_r >= 32'(INIT_CLK - 1)) begin
                        st_r <= SPS_D_STBY;
                        tmr_r <= 32'h0;
                    end else begin
                        tmr_r <= tmr_r + 32'h1;
                    end
                end
                SPS_D_STBY: begin
                    tmr_r <= 32'h0;
                    if (run_r[0]) begin
                        st_r <= SPS_D_WAKE;
                    end
                end
                SPS_D_WAKE: begin
                    if (!run_r[0]) begin
                        st_r <= SPS_D_STBY; // Aborted before first frame
                    end else if (tmr_r >= wake_len - 32'h1) begin
                        st_r <= SPS_D_STREAM;
                    end else begin
                        tmr_r <= tmr_r + 32'h1;
                    end
                end
                SPS_D_STREAM: begin
                    if (!run_r[0]) begin
                        if (in_blank) begin
                            st_r <= SPS_D_STBY;
                        end else if (fast_r == `SPS_FAST_ON && line_end) begin
                            st_r <= SPS_D_STBY;
                        end else if (act_end) begin
                            st_r <= SPS_D_STBY;
                        end
                    end
                end
                default: st_r <= SPS_D_RST;
            endcase
        end
    end

    // Quality rises after first frame
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            qok_r <= 1'b0;
        end else if (st_r != SPS_D_STREAM) begin
            qok_r <= 1'b0;
        end else if (act_end) begin
            qok_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign LINK.cci_ack = ack_r;
    assign LINK.cci_rdata = rdata_r;
    assign LINK.standby = (st_r != SPS_D_STREAM) && (st_r != SPS_D_WAKE);
    assign LINK.frame_valid = (st_r == SPS_D_STREAM) && !in_blank;
    assign LINK.line_valid = LINK.frame_valid && (col_r < `SPS_ACT_COLS);
    assign LINK.quality_ok = qok_r;
    assign INT_RST_N_O = int_rst_n_r;
    assign STATE_O = st_r;

endmodule
`default_nettype wire

// file: sps_host.sv
// Host end: APB registers, clear pin sequencing and control writes to the sensor
`include "sps_regs.svh"
`default_nettype none
module sps_host
    import sps_pkg::*;
#(
    parameter int VREF_CYC = `SPS_VREF_CYC // Reference node charge wait
) (
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    sps_link_if.host LINK
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] ctrl_r; // Power, run, fast
    logic [7:0] expo_r; // Exposure to program
    logic clr_r; // Clear pin level
    logic [31:0] vref_cnt_r; // Time since clear rose
    logic vref_ok; // Charge wait done
    sps_host_st_t st_r; // Command state
    logic run_sent_r; // Run state last written
    logic tgt_run; // Wanted run state
    logic apb_acc; // APB access phase
    logic map_hit; // Address decodes
    logic [31:0] stat; // Status word

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    assign apb_acc = PSEL_I && PENABLE_I;
    assign map_hit = (PADDR_I == `SPS_APB_CTRL) || (PADDR_I == `SPS_APB_EXPO) ||
                     (PADDR_I == `SPS_APB_STAT);
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = apb_acc && !map_hit;

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctrl_r <= 3'h0;
            expo_r <= 8'h00;
        end else if (apb_acc && PWRITE_I) begin
            if (PADDR_I == `SPS_APB_CTRL) begin
                ctrl_r <= PWDATA_I[2:0];
            end
            if (PADDR_I == `SPS_APB_EXPO) begin
                expo_r <= PWDATA_I[7:0];
            end
        end
    end

    // Status word
    always_comb begin
        stat = 32'h0;
        stat[`SPS_ST_CLR] = clr_r;
        stat[`SPS_ST_STBY] = LINK.standby;
        stat[`SPS_ST_FV] = LINK.frame_valid;
        stat[`SPS_ST_QOK] = LINK.quality_ok;
        stat[`SPS_ST_BUSY] = (st_r != SPS_H_IDLE);
        stat[`SPS_ST_VREF] = vref_ok;
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            PRDATA_O <= 32'h0;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            case (PADDR_I)
                `SPS_APB_CTRL: PRDATA_O <= {29'h0, ctrl_r};
                `SPS_APB_EXPO: PRDATA_O <= {24'h0, expo_r};
                `SPS_APB_STAT: PRDATA_O <= stat;
                default: PRDATA_O <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Clear pin
    // ------------------------------------------------------------
    // Power bit means rails are up; clear falls only in standby, link idle
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            clr_r <= 1'b0;
        end else if (ctrl_r[`SPS_CTRL_PWR]) begin
            clr_r <= 1'b1;
        end else if (LINK.standby && !run_sent_r && st_r == SPS_H_IDLE) begin
            clr_r <= 1'b0;
        end
    end

    // Charge wait restarts while clear is low
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            vref_cnt_r <= 32'h0;
        end else if (!clr_r) begin
            vref_cnt_r <= 32'h0;
        end else if (!vref_ok) begin
            vref_cnt_r <= vref_cnt_r + 32'h1;
        end
    end
    assign vref_ok = (vref_cnt_r >= 32'(VREF_CYC));

    // ------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------
    // Start needs the charge wait; stop is always allowed
    assign tgt_run = ctrl_r[`SPS_CTRL_RUN] && ctrl_r[`SPS_CTRL_PWR];

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_r <= SPS_H_IDLE;
            run_sent_r <= 1'b0;
        end else if (!clr_r) begin
            st_r <= SPS_H_IDLE;
            run_sent_r <= 1'b0;
        end else begin
            case (st_r)
                SPS_H_IDLE: begin
                    if (tgt_run && !run_sent_r && vref_ok) begin
                        st_r <= SPS_H_FAST;
                    end else if (!tgt_run && run_sent_r) begin
                        st_r <= SPS_H_FAST;
                    end
                end
                SPS_H_FAST: begin
                    if (LINK.cci_ack) begin
                        st_r <= run_sent_r ? SPS_H_RUN : SPS_H_EXPO;
                    end
                end
                SPS_H_EXPO: begin
                    if (LINK.cci_ack) begin
                        st_r <= SPS_H_RUN;
                    end
                end
                SPS_H_RUN: begin
                    if (LINK.cci_ack) begin
                        st_r <= SPS_H_IDLE;
                        run_sent_r <= !run_sent_r;
                    end
                end
                default: st_r <= SPS_H_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Link drive
    // ------------------------------------------------------------
    // Request held until ack
    assign LINK.cci_req = (st_r != SPS_H_IDLE) && !LINK.cci_ack;
    assign LINK.cci_we = 1'b1;
    always_comb begin
        case (st_r)
            SPS_H_FAST: LINK.cci_addr = `SPS_ADR_FAST;
            SPS_H_EXPO: LINK.cci_addr = `SPS_ADR_EXPO;
            default: LINK.cci_addr = `SPS_ADR_RUN;
        endcase
    end
    always_comb begin
        case (st_r)
            SPS_H_FAST: LINK.cci_wdata = ctrl_r[`SPS_CTRL_FAST] ? `SPS_FAST_ON : 8'h00;
            SPS_H_EXPO: LINK.cci_wdata = expo_r;
            SPS_H_RUN: LINK.cci_wdata = run_sent_r ? `SPS_RUN_OFF : `SPS_RUN_ON;
            default: LINK.cci_wdata = 8'h00;
        endcase
    end
    assign LINK.ext_clear_n = clr_r;

endmodule
`default_nettype wire

// file: sps_link_props.sv
// Concurrent checks on the host to sensor link and the sensor state
`include "sps_regs.svh"
`default_nettype none
module sps_link_props #(
    parameter int REL_CYC = 16,
    parameter int INIT_CLK = 20,
    parameter int WAKE_CYC = 30
) (
    input wire logic CLK_SYS_I,
    input wire logic ARST_N_I,
    input wire logic ext_clear_n,
    input wire logic cci_req,
    input wire logic [15:0] cci_addr,
    input wire logic [7:0] cci_wdata,
    input wire logic cci_ack,
    input wire logic standby,
    input wire logic frame_valid,
    input wire logic line_valid,
    input wire logic quality_ok,
    input wire logic INT_RST_N_O,
    input wire logic [2:0] STATE_O
);
    // --------------------------------------------------------------
    // Helper logic
    // --------------------------------------------------------------
    localparam int REL_BND = REL_CYC + 2; // Two edges of slack
    localparam int INIT_BND = INIT_CLK + 3; // Init plus state hops
    logic [7:0] expo_r; // Exposure as written on the link
    logic [31:0] wake_cnt_r; // Cycles spent in wake-up
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I);
    // Exposure as taken on the link
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            expo_r <= 8'h00;
        end else if (cci_req && !cci_ack && cci_addr == `SPS_ADR_EXPO) begin
            expo_r <= cci_wdata;
        end
    end
    // Wake cycles
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wake_cnt_r <= 32'h0;
        end else begin
            wake_cnt_r <= (STATE_O == 3'd3) ? wake_cnt_r + 32'h1 : 32'h0;
        end
    end
    // --------------------------------------------------------------
    // Sequences and assertions
    // --------------------------------------------------------------
    // Acked stop write
    sequence stop_s;
        cci_ack && $past(cci_addr) == `SPS_ADR_RUN && $past(cci_wdata) == `SPS_RUN_OFF;
    endsequence
    // Blanking while streaming
    sequence blank_s;
        !frame_valid && !$past(frame_valid) && $past(STATE_O) == 3'd4;
    endsequence
    rst_fall_a: assert property (!ext_clear_n |=> !INT_RST_N_O)
        else $error("reset did not follow clear");
    rst_rise_a: assert property ($rose(ext_clear_n) |-> ##[1:REL_BND] INT_RST_N_O)
        else $error("reset release late");
    init_len_a: assert property ($rose(INT_RST_N_O) |-> ##[1:INIT_BND] STATE_O == 3'd2)
        else $error("silicon init too long");
    rst_hold_a: assert property (!INT_RST_N_O |=> STATE_O == 3'd0 && standby)
        else $error("state moved in reset");
    wake_min_a: assert property (
        STATE_O == 3'd4 && $past(STATE_O) == 3'd3 |->
        frame_valid && int'(wake_cnt_r) >= WAKE_CYC + 64 * int'(expo_r) - 1)
        else $error("stream started too early");
    blank_stop_a: assert property (stop_s ##0 blank_s |-> ##[0:2] standby)
        else $error("blanking stop late");
    no_cut_a: assert property ($rose(standby) |-> !$past(line_valid))
        else $error("standby cut a line");
    line_len_a: assert property ($rose(line_valid) |-> ##47 line_valid ##1 !line_valid)
        else $error("line length wrong");
    stby_dark_a: assert property (standby |-> !frame_valid && !line_valid)
        else $error("output active in standby");
    qual_rise_a: assert property ($fell(frame_valid) && !standby |-> ##[0:1] quality_ok)
        else $error("quality late");
    clr_order_a: assert property ($fell(ext_clear_n) |-> standby && $past(standby))
        else $error("clear fell outside standby");
endmodule
`default_nettype wire

// file: sensor_power_standby_seq_tb.sv
// Testbench: both ends joined, driven over APB
`include "sps_regs.svh"
`default_nettype none
module sensor_power_standby_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------------
    // Signals
    // --------------------------------------------------------------
    logic clk_sys, arst_n, psel, penable, pwrite, pready, pslverr, int_rst_n, lv_d, fv_d;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] state, ctrl;
    logic [7:0] expo; // Exposure in lines
    logic [32:0] exp_q[$], msk_q[$]; // Notes {error, data}, masks
    int fails, check_count, cyc_cnt, lines, t0;
    sps_link_if link ();
    sps_dev #(.REL_CYC(16), .INIT_CLK(20), .WAKE_CYC(30)) i_sps_dev (.CLK_SYS_I(clk_sys),
        .ARST_N_I(arst_n), .LINK(link.dev), .INT_RST_N_O(int_rst_n), .STATE_O(state));
    sps_host #(.VREF_CYC(40)) i_sps_host (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .LINK(link.host));
    sps_link_props u_props (
        .CLK_SYS_I(clk_sys), .ARST_N_I(arst_n), .ext_clear_n(link.ext_clear_n),
        .cci_req(link.cci_req), .cci_addr(link.cci_addr), .cci_wdata(link.cci_wdata),
        .cci_ack(link.cci_ack), .standby(link.standby), .frame_valid(link.frame_valid),
        .line_valid(link.line_valid), .quality_ok(link.quality_ok),
        .INT_RST_N_O(int_rst_n), .STATE_O(state));
    // --------------------------------------------------------------
    // Clock, tasks and watchers
    // --------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // One APB transfer, started after an edge
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        input logic [32:0] exp, input logic [32:0] msk);
        exp_q.push_back(exp);
        msk_q.push_back(msk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Compare each finished transfer with its note
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1) begin
            check({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    // Active lines in this frame
    always @(posedge clk_sys) begin
        lv_d <= link.line_valid;
        fv_d <= link.frame_valid;
        if (link.frame_valid && !fv_d) lines <= (link.line_valid && !lv_d) ? 1 : 0;
        else if (link.line_valid && !lv_d) lines <= lines + 1;
    end
    // Hang guard
    always @(posedge clk_sys) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 40000) begin
            fails++;
            conclude();
        end
    end
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {fails, check_count, cyc_cnt, lines, t0} = '0;
        {lv_d, fv_d, ctrl} = '0;
        void'($urandom(32'h3f752d7a));
        expo = 8'($urandom_range(3, 0));
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        xfer(1'b0, `SPS_APB_STAT, 0, 33'h0_0000_0002, 33'h1_0000_002e);
        xfer(1'b0, 12'h00c, 0, 33'h1_0000_0000, 33'h1_ffff_ffff);
        xfer(1'b1, 12'hffc, 32'h0000_00ff, 33'h1_0000_0000, 33'h1_0000_0000);
        xfer(1'b1, `SPS_APB_EXPO, {24'h0, expo}, 0, 33'h1_0000_0000);
        xfer(1'b0, `SPS_APB_EXPO, 0, {25'h0, expo}, 33'h1_0000_00ff);
        xfer(1'b1, `SPS_APB_CTRL, 32'h1, 0, 33'h1_0000_0000);
        while (int_rst_n !== 1'b1) @(posedge clk_sys);
        xfer(1'b0, `SPS_APB_STAT, 0, 33'h0_0000_0002, 33'h1_0000_0022);
        repeat (60) @(posedge clk_sys);
        xfer(1'b0, `SPS_APB_STAT, 0, 33'h0_0000_0022, 33'h1_0000_0022);
        check({30'h0, state}, 33'h2);
        // Stop in blanking, in frame, fast
        for (int m = 0; m < 3; m++) begin
            ctrl = (m == 2) ? 3'b111 : 3'b011;
            xfer(1'b1, `SPS_APB_CTRL, {29'h0, ctrl}, 0, 33'h1_0000_0000);
            xfer(1'b0, `SPS_APB_CTRL, 0, {30'h0, ctrl}, 33'h1_0000_0007);
            while (link.standby !== 1'b0) @(posedge clk_sys);
            t0 = cyc_cnt;
            while (link.frame_valid !== 1'b1) @(posedge clk_sys);
            check({32'h0, (cyc_cnt - t0) >= 30 + 64 * expo}, 33'h1);
            if (m == 0) begin
                while (link.frame_valid !== 1'b0) @(posedge clk_sys);
                xfer(1'b0, `SPS_APB_STAT, 0, 33'h0_0000_0008, 33'h1_0000_000e);
            end
            t0 = cyc_cnt;
            xfer(1'b1, `SPS_APB_CTRL, {29'h0, ctrl & 3'b101}, 0, 33'h1_0000_0000);
            while (link.standby !== 1'b1) @(posedge clk_sys);
            if (m == 0) check({32'h0, (cyc_cnt - t0) < 16}, 33'h1);
            else if (m == 1) check({32'h0, lines == 32 && cyc_cnt - t0 <= 2600}, 33'h1);
            else check({32'h0, lines < 32}, 33'h1);
            repeat (4) @(posedge clk_sys);
        end
        // Power down from standby
        xfer(1'b1, `SPS_APB_CTRL, 0, 0, 33'h1_0000_0000);
        while (int_rst_n !== 1'b0) @(posedge clk_sys);
        xfer(1'b0, `SPS_APB_STAT, 0, 33'h0_0000_0002, 33'h1_0000_000e);
        conclude();
    end
endmodule
`default_nettype wire
